/* File: design/bsl_loader.sv */
// Behaviour
// [RULE_01] Parallel modes detect width before sync hunt
// [RULE_02] Serial, SPI, JTAG ignore width pattern
// [RULE_03] Sync word aligns following words
// [RULE_04] Data before sync dropped, except width pattern
// [RULE_05] Aligned flag shown only during port abort
// [RULE_06] Width status: 00 x1, 01 x8, 10 x16, 11 x32
// [RULE_07] Internal port width shown after configuration
// [RULE_08] No frames until identity check passes
// [RULE_09] Identity failure starts fallback
// [RULE_10] Identity check driven by stream commands
// [RULE_11] Identity word: version, family, array, company, one
// [RULE_12] Frames only after sync and identity
// [RULE_13] CRC accumulated over loaded packet data
// [RULE_14] CRC mismatch pulls init low, aborts
// [RULE_15] Stream producer should include CRC check
// [RULE_16] Encrypted: skip CRC, record HMAC error
// [RULE_17] CRC error in master modes may fall back
// [RULE_18] Flash/SPI dead after failed fallback till reprogram
// [RULE_19] Port host recovers by reprogram or abort
// [RULE_20] Integrity check uses 32-bit CRC
// [RULE_21] Lost alignment: no commands, done low, init high
// [RULE_22] Async flash address wrap forces fallback
// [RULE_23] Init rise samples mode, parallel starts x8
// [RULE_24] Sliding 32-bit window matched against sync word
`timescale 1ns/1ps
module bsl_loader #(
	parameter int unsigned ADDR_W      = 10,
	parameter int unsigned FLASH_AW    = 16,
	parameter logic [3:0]  ID_VERSION  = 4'h0,  // Arbitrary value
	parameter logic [6:0]  ID_FAMILY   = 7'h01, // Arbitrary value
	parameter logic [3:0]  ID_SUBFAM   = 4'h1,  // Arbitrary value
	parameter logic [4:0]  ID_DEVICE   = 5'h01, // Arbitrary value
	parameter logic [10:0] ID_COMPANY  = 11'h001 // Arbitrary value
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Configuration pins
	input  wire logic                config_clock,
	input  wire logic [31:0]         cfg_data,
	input  wire logic [2:0]          mode_pins,
	input  wire logic                prog_n,
	input  wire logic                abort_req,
	// Init open-drain pin
	input  wire logic                init_i,
	output logic                     init_o,
	output logic                     init_oe_n,
	// Done open-drain pin
	input  wire logic                done_i,
	output logic                     done_o,
	output logic                     done_oe_n,
	// Internal port and decryptor
	input  wire logic                icap_en,
	input  wire logic [1:0]          icap_width,
	input  wire logic                hmac_fail,
	// Status
	output logic [31:0]              identity_word,
	output logic [1:0]               detected_width,
	output logic                     sync_aligned_flag,
	output logic [bsl_pkg::BS_W-1:0] boot_status_reg,
	output logic                     fallback_req,
	output logic                     port_dead,
	output logic [FLASH_AW-1:0]      flash_addr,
	// Frame readback
	input  wire logic [ADDR_W-1:0]   rd_addr,
	output logic [31:0]              rd_data
);
	// Elaboration checks
	if (ADDR_W < 2 || ADDR_W > 16) begin : g_bad_addr
		$error("ADDR_W out of range");
	end
	if (FLASH_AW < 4 || FLASH_AW > 32) begin : g_bad_faddr
		$error("FLASH_AW out of range");
	end

	localparam int SY_W = 39;

	// Two-stage synchronisers for every pin input
	logic [SY_W-1:0] sy1_q;
	logic [SY_W-1:0] sy2_q;
	logic            config_clock_prev_q;
	logic            abort_prev_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_q        <= '0;
			sy2_q        <= '0;
			config_clock_prev_q  <= 1'b0;
			abort_prev_q <= 1'b0;
		end else begin
			sy1_q        <= {cfg_data, config_clock, mode_pins, prog_n, abort_req, done_i};
			sy2_q        <= sy1_q;
			config_clock_prev_q  <= sy2_q[6];
			abort_prev_q <= sy2_q[1];
		end
	end

	logic [31:0] dat_s;
	logic [2:0]  mode_s;
	logic        prog_s;
	logic        abort_s;
	logic        done_s;
	logic        init_s;
	logic        init_sy1_q;
	logic        init_sy2_q;
	logic        config_clock_rise;

	// Init pin synchroniser kept apart, it is read before alignment
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_sy1_q <= 1'b0;
			init_sy2_q <= 1'b0;
		end else begin
			init_sy1_q <= init_i;
			init_sy2_q <= init_sy1_q;
		end
	end

	// Field split of the synchronised pins
	assign dat_s     = sy2_q[38:7];
	assign mode_s    = sy2_q[5:3];
	assign prog_s    = sy2_q[2];
	assign abort_s   = sy2_q[1];
	assign done_s    = sy2_q[0];
	assign init_s    = init_sy2_q;
	assign config_clock_rise = sy2_q[6] & ~config_clock_prev_q;

	// Bitwise CRC step over one 32-bit word
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? bsl_pkg::CRC_POLY : 32'h00000000);
		end
		return r;
	endfunction

	// Identity word assembled from its fields
	assign identity_word = {ID_VERSION, ID_FAMILY, ID_SUBFAM, ID_DEVICE, ID_COMPANY, 1'b1}; // see [RULE_11]

	bsl_pkg::bsl_state_t       st_q, st_d;
	bsl_pkg::bsl_mode_t        mode_q, mode_d;
	logic [15:0]               cnt_q, cnt_d;
	logic [1:0]                width_q, width_d;
	logic                      wdet_q, wdet_d;
	logic                      aligned_q, aligned_d;
	logic [31:0]               win_q, win_d;
	logic [5:0]                bitc_q, bitc_d;
	logic [31:0]               crc_q, crc_d;
	logic                      id_ok_q, id_ok_d;
	logic                      enc_q, enc_d;
	logic [bsl_pkg::BS_W-1:0]  bs_q, bs_d;
	logic                      fb_used_q, fb_used_d;
	logic                      fb_pulse_q, fb_pulse_d;
	logic [FLASH_AW-1:0]       faddr_q, faddr_d;
	logic [ADDR_W-1:0]         waddr_q, waddr_d;
	logic                      we_q, we_d;
	logic [31:0]               wdata_q, wdata_d;
	logic                      done_rel_q, done_rel_d;
	logic                      cfg_done_q, cfg_done_d;

	// Mode classes
	logic is_par;
	logic is_master;
	logic is_flash;
	logic is_port;
	assign is_par    = mode_q inside {bsl_pkg::MODE_FLASH_ASYNC, bsl_pkg::MODE_FLASH_SYNC,
		bsl_pkg::MODE_PORT_MASTER, bsl_pkg::MODE_PORT_SLAVE};
	assign is_master = mode_q inside {bsl_pkg::MODE_SERIAL_MASTER, bsl_pkg::MODE_SPI,
		bsl_pkg::MODE_FLASH_ASYNC, bsl_pkg::MODE_FLASH_SYNC, bsl_pkg::MODE_PORT_MASTER};
	assign is_flash  = mode_q inside {bsl_pkg::MODE_FLASH_ASYNC, bsl_pkg::MODE_FLASH_SYNC};
	assign is_port   = mode_q inside {bsl_pkg::MODE_PORT_MASTER, bsl_pkg::MODE_PORT_SLAVE};

	// Window shift by the current bus width
	logic [31:0] win_n;
	logic [5:0]  step;
	logic [5:0]  bits_n;
	logic        word_v;
	always_comb begin
		unique case (width_q)
			bsl_pkg::W_X1: begin
				win_n = {win_q[30:0], dat_s[0]};
				step  = 6'h01;
			end
			bsl_pkg::W_X8: begin
				win_n = {win_q[23:0], dat_s[7:0]};
				step  = 6'h08;
			end
			bsl_pkg::W_X16: begin
				win_n = {win_q[15:0], dat_s[15:0]};
				step  = 6'h10;
			end
			bsl_pkg::W_X32: begin
				win_n = dat_s;
				step  = 6'h20;
			end
		endcase
		bits_n = bitc_q + step;
		word_v = config_clock_rise && aligned_q && (bits_n == 6'h20); // see [RULE_03]
	end

	// Loader next state
	logic fail;
	logic fb_ok;
	logic hunt_go;
	always_comb begin
		st_d       = st_q;
		mode_d     = mode_q;
		cnt_d      = cnt_q;
		width_d    = width_q;
		wdet_d     = wdet_q;
		aligned_d  = aligned_q;
		win_d      = win_q;
		bitc_d     = bitc_q;
		crc_d      = crc_q;
		id_ok_d    = id_ok_q;
		enc_d      = enc_q;
		bs_d       = bs_q;
		fb_used_d  = fb_used_q;
		fb_pulse_d = 1'b0;
		faddr_d    = faddr_q;
		waddr_d    = waddr_q;
		we_d       = 1'b0;
		wdata_d    = wdata_q;
		done_rel_d = done_rel_q;
		cfg_done_d = cfg_done_q;
		fail       = 1'b0;
		fb_ok      = 1'b0;
		hunt_go    = 1'b0;

		// Word assembly once aligned; the window slides on every edge
		if (config_clock_rise && aligned_q) begin
			win_d  = win_n;
			bitc_d = word_v ? 6'h00 : bits_n;
		end

		// Flash reads advance on each edge; wrap in async read falls back
		if (config_clock_rise && is_flash && !(st_q inside {bsl_pkg::ST_INIT, bsl_pkg::ST_WAIT,
				bsl_pkg::ST_DONE, bsl_pkg::ST_ERROR, bsl_pkg::ST_DEAD})) begin
			faddr_d = faddr_q + 1'b1;
			if (mode_q == bsl_pkg::MODE_FLASH_ASYNC && &faddr_q) begin // see [RULE_22]
				bs_d[bsl_pkg::BS_WRAP_ERR] = 1'b1;
				fail  = 1'b1;
				fb_ok = 1'b1;
			end
		end

		unique case (st_q)
			bsl_pkg::ST_INIT: begin
				cnt_d = cnt_q + 16'h0001;
				if (cnt_q == bsl_pkg::INIT_LOW_CYC - 16'h0001) begin
					st_d = bsl_pkg::ST_WAIT;
				end
			end
			bsl_pkg::ST_WAIT: begin
				if (init_s) begin // see [RULE_23]
					if (!fb_used_q) begin
						mode_d = bsl_pkg::bsl_mode_t'(mode_s);
					end
					hunt_go = 1'b1;
				end
			end
			bsl_pkg::ST_HUNT: begin
				if (config_clock_rise) begin
					if (is_par && !wdet_q) begin // see [RULE_01] [RULE_04]
						wdet_d = (dat_s == bsl_pkg::DET_X8) || (dat_s == bsl_pkg::DET_X16)
							|| (dat_s == bsl_pkg::DET_X32);
						if (dat_s == bsl_pkg::DET_X16) begin
							width_d = bsl_pkg::W_X16;
						end else if (dat_s == bsl_pkg::DET_X32) begin
							width_d = bsl_pkg::W_X32;
						end
					end else begin
						win_d = win_n; // see [RULE_02] [RULE_24]
						if (win_n == bsl_pkg::SYNC_WORD) begin // see [RULE_03]
							aligned_d = 1'b1;
							bitc_d    = 6'h00;
							crc_d     = bsl_pkg::CRC_INIT;
							st_d      = bsl_pkg::ST_CMD;
						end
					end
				end
			end
			bsl_pkg::ST_CMD: begin
				if (word_v) begin
					crc_d = crc_step(crc_q, win_n); // see [RULE_13] [RULE_20]
					unique case (win_n[bsl_pkg::OP_MSB:bsl_pkg::OP_LSB])
						bsl_pkg::OP_NOP: ;
						bsl_pkg::OP_ID: st_d = bsl_pkg::ST_ID; // see [RULE_10]
						bsl_pkg::OP_FRAMES: begin
							cnt_d = win_n[bsl_pkg::CNT_MSB:bsl_pkg::CNT_LSB];
							if (win_n[bsl_pkg::CNT_MSB:bsl_pkg::CNT_LSB] != 16'h0000) begin
								st_d = bsl_pkg::ST_FRAMES;
							end
						end
						bsl_pkg::OP_CRC: st_d = bsl_pkg::ST_CRC;
						bsl_pkg::OP_ENC: enc_d = 1'b1;
						bsl_pkg::OP_END: begin
							if (id_ok_q) begin
								done_rel_d = 1'b1;
								st_d       = bsl_pkg::ST_DONE;
							end
						end
						default: begin // Garbled command means word alignment is gone
							aligned_d = 1'b0; // see [RULE_21]
							bs_d[bsl_pkg::BS_DESYNC] = 1'b1;
							st_d = bsl_pkg::ST_DESYNC;
						end
					endcase
				end
			end
			bsl_pkg::ST_ID: begin
				if (word_v) begin
					crc_d = crc_step(crc_q, win_n);
					if (win_n == identity_word) begin // see [RULE_08]
						id_ok_d = 1'b1;
						st_d    = bsl_pkg::ST_CMD;
					end else begin // see [RULE_09]
						bs_d[bsl_pkg::BS_ID_ERR] = 1'b1;
						fail  = 1'b1;
						fb_ok = 1'b1;
					end
				end
			end
			bsl_pkg::ST_FRAMES: begin
				if (word_v) begin
					crc_d = crc_step(crc_q, win_n); // see [RULE_13]
					cnt_d = cnt_q - 16'h0001;
					if (id_ok_q && aligned_q) begin // see [RULE_12]
						we_d    = 1'b1;
						wdata_d = win_n;
						waddr_d = waddr_q + 1'b1;
					end
					if (cnt_q == 16'h0001) begin
						st_d = bsl_pkg::ST_CMD;
					end
				end
			end
			bsl_pkg::ST_CRC: begin
				if (word_v) begin
					st_d = bsl_pkg::ST_CMD;
					if (enc_q) begin // see [RULE_16]
						if (hmac_fail) begin
							bs_d[bsl_pkg::BS_HMAC_ERR] = 1'b1;
							st_d = bsl_pkg::ST_ERROR;
						end
					end else if (win_n != crc_q) begin // see [RULE_14]
						bs_d[bsl_pkg::BS_CRC_ERR] = 1'b1;
						fail  = 1'b1;
						fb_ok = is_master; // see [RULE_17]
					end
				end
			end
			bsl_pkg::ST_DONE: begin
				if (done_s) begin
					cfg_done_d = 1'b1;
				end
			end
			bsl_pkg::ST_ERROR, bsl_pkg::ST_DESYNC, bsl_pkg::ST_DEAD: ;
		endcase

		// One fallback try, then the flash/SPI path locks up
		if (fail) begin
			if (fb_ok && !fb_used_q) begin
				fb_used_d  = 1'b1;
				fb_pulse_d = 1'b1;
				bs_d[bsl_pkg::BS_FALLBACK] = 1'b1;
				cnt_d      = 16'h0000;
				st_d       = bsl_pkg::ST_INIT;
			end else if (fb_used_q && (is_flash || mode_q == bsl_pkg::MODE_SPI)) begin
				st_d = bsl_pkg::ST_DEAD; // see [RULE_18]
			end else begin
				st_d = bsl_pkg::ST_ERROR; // see [RULE_14]
			end
		end

		// Port abort: data frozen while held, hunt restarts on release
		if (is_port && abort_s && !(st_q inside {bsl_pkg::ST_INIT, bsl_pkg::ST_WAIT})) begin
			st_d = st_q;
			we_d = 1'b0;
			win_d = win_q;
			bitc_d = bitc_q;
			aligned_d = aligned_q;
		end else if (is_port && abort_prev_q && !abort_s
				&& !(st_q inside {bsl_pkg::ST_INIT, bsl_pkg::ST_WAIT})) begin
			hunt_go = 1'b1; // see [RULE_19]
		end

		if (hunt_go) begin
			width_d   = is_par ? bsl_pkg::W_X8 : bsl_pkg::W_X1; // see [RULE_23]
			if (st_q == bsl_pkg::ST_WAIT && !fb_used_q) begin
				width_d = (mode_s inside {bsl_pkg::MODE_FLASH_ASYNC, bsl_pkg::MODE_FLASH_SYNC,
					bsl_pkg::MODE_PORT_MASTER, bsl_pkg::MODE_PORT_SLAVE})
					? bsl_pkg::W_X8 : bsl_pkg::W_X1;
			end
			wdet_d    = (width_d == bsl_pkg::W_X1);
			aligned_d = 1'b0;
			win_d     = 32'h00000000;
			bitc_d    = 6'h00;
			id_ok_d   = 1'b0;
			enc_d     = 1'b0;
			st_d      = bsl_pkg::ST_HUNT;
		end

		// Reprogram pin restarts everything, mode sampled again
		if (!prog_s) begin
			st_d       = bsl_pkg::ST_INIT;
			cnt_d      = 16'h0000;
			bs_d       = bsl_pkg::BS_RESET;
			fb_used_d  = 1'b0;
			aligned_d  = 1'b0;
			width_d    = bsl_pkg::W_X1; // Stale width must not show while waiting
			id_ok_d    = 1'b0;
			done_rel_d = 1'b0;
			cfg_done_d = 1'b0;
			faddr_d    = '0;
			waddr_d    = '0;
			we_d       = 1'b0;
		end
	end

	// Loader registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q       <= bsl_pkg::ST_INIT;
			mode_q     <= bsl_pkg::MODE_SERIAL_MASTER;
			cnt_q      <= 16'h0000;
			width_q    <= bsl_pkg::W_X1;
			wdet_q     <= 1'b1;
			aligned_q  <= 1'b0;
			win_q      <= 32'h00000000;
			bitc_q     <= 6'h00;
			crc_q      <= bsl_pkg::CRC_INIT;
			id_ok_q    <= 1'b0;
			enc_q      <= 1'b0;
			bs_q       <= bsl_pkg::BS_RESET;
			fb_used_q  <= 1'b0;
			fb_pulse_q <= 1'b0;
			faddr_q    <= '0;
			waddr_q    <= '0;
			we_q       <= 1'b0;
			wdata_q    <= 32'h00000000;
			done_rel_q <= 1'b0;
			cfg_done_q <= 1'b0;
		end else begin
			st_q       <= st_d;
			mode_q     <= mode_d;
			cnt_q      <= cnt_d;
			width_q    <= width_d;
			wdet_q     <= wdet_d;
			aligned_q  <= aligned_d;
			win_q      <= win_d;
			bitc_q     <= bitc_d;
			crc_q      <= crc_d;
			id_ok_q    <= id_ok_d;
			enc_q      <= enc_d;
			bs_q       <= bs_d;
			fb_used_q  <= fb_used_d;
			fb_pulse_q <= fb_pulse_d;
			faddr_q    <= faddr_d;
			waddr_q    <= waddr_d;
			we_q       <= we_d;
			wdata_q    <= wdata_d;
			done_rel_q <= done_rel_d;
			cfg_done_q <= cfg_done_d;
		end
	end

	// Frame store; write address is the one before the increment
	bsl_frame_mem #(
		.ADDR_W (ADDR_W),
		.DATA_W (32)
	) u_mem (
		.clk   (clk),
		.we    (we_q),
		.waddr (waddr_q - 1'b1),
		.wdata (wdata_q),
		.raddr (rd_addr),
		.rdata (rd_data)
	);

	// Pin and status outputs; desync leaves init released and done low
	assign init_o            = 1'b0;
	assign init_oe_n         = !(st_q inside {bsl_pkg::ST_INIT, bsl_pkg::ST_ERROR,
		bsl_pkg::ST_DEAD}); // see [RULE_14] [RULE_21]
	assign done_o            = 1'b0;
	assign done_oe_n         = done_rel_q;
	assign detected_width    = (icap_en && cfg_done_q) ? icap_width : width_q; // see [RULE_06] [RULE_07]
	assign sync_aligned_flag = is_port && abort_s && aligned_q; // see [RULE_05]
	assign boot_status_reg   = bs_q;
	assign fallback_req      = fb_pulse_q;
	assign port_dead         = (st_q == bsl_pkg::ST_DEAD);
	assign flash_addr        = faddr_q;
endmodule // bsl_loader

/* File: design/bsl_pkg.sv */
package bsl_pkg;
	// Stream alignment and integrity
	localparam logic [31:0] SYNC_WORD = 32'hAA995566;
	localparam logic [31:0] CRC_POLY  = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT  = 32'h00000000;

	// Detected bus width codes
	localparam logic [1:0] W_X1  = 2'h0;
	localparam logic [1:0] W_X8  = 2'h1;
	localparam logic [1:0] W_X16 = 2'h2;
	localparam logic [1:0] W_X32 = 2'h3;

	// Width detection patterns as seen on the raw bus
	localparam logic [31:0] DET_X8  = 32'h000000A1;
	localparam logic [31:0] DET_X16 = 32'h0000A1A2;
	localparam logic [31:0] DET_X32 = 32'hA1A2A3A4;

	// Command word layout
	localparam int OP_MSB  = 31;
	localparam int OP_LSB  = 28;
	localparam int CNT_MSB = 15;
	localparam int CNT_LSB = 0;
	localparam logic [3:0] OP_NOP    = 4'h0;
	localparam logic [3:0] OP_ID     = 4'h1;
	localparam logic [3:0] OP_FRAMES = 4'h2;
	localparam logic [3:0] OP_CRC    = 4'h3;
	localparam logic [3:0] OP_ENC    = 4'h4;
	localparam logic [3:0] OP_END    = 4'h5;

	// Identity word field positions
	localparam int ID_VER_LSB = 28;
	localparam int ID_FAM_LSB = 21;
	localparam int ID_SUB_LSB = 17;
	localparam int ID_DEV_LSB = 12;
	localparam int ID_CO_LSB  = 1;

	// Boot status bits
	localparam int BS_ID_ERR   = 0;
	localparam int BS_CRC_ERR  = 1;
	localparam int BS_HMAC_ERR = 2;
	localparam int BS_WRAP_ERR = 3;
	localparam int BS_DESYNC   = 4;
	localparam int BS_FALLBACK = 5;
	localparam int BS_W        = 6;
	localparam logic [BS_W-1:0] BS_RESET = 6'h00;

	// Init pin low time after reset or fallback
	localparam int CLK_PERIOD_NS = 4;
	localparam int INIT_LOW_NS   = 1000;
	localparam logic [15:0] INIT_LOW_CYC =
		16'((INIT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Configuration modes on the mode pins
	typedef enum logic [2:0] {
		MODE_SERIAL_MASTER = 3'h0,
		MODE_SPI           = 3'h1,
		MODE_FLASH_ASYNC   = 3'h2,
		MODE_FLASH_SYNC    = 3'h3,
		MODE_PORT_MASTER   = 3'h4,
		MODE_JTAG          = 3'h5,
		MODE_PORT_SLAVE    = 3'h6,
		MODE_SERIAL_SLAVE  = 3'h7
	} bsl_mode_t;

	// Loader states
	typedef enum logic [10:0] {
		ST_INIT   = 11'h001,
		ST_WAIT   = 11'h002,
		ST_HUNT   = 11'h004,
		ST_CMD    = 11'h008,
		ST_ID     = 11'h010,
		ST_FRAMES = 11'h020,
		ST_CRC    = 11'h040,
		ST_DONE   = 11'h080,
		ST_ERROR  = 11'h100,
		ST_DESYNC = 11'h200,
		ST_DEAD   = 11'h400
	} bsl_state_t;
endpackage

/* File: design/bsl_frame_mem.sv */
`timescale 1ns/1ps
module bsl_frame_mem #(
	parameter int unsigned ADDR_W = 10,
	parameter int unsigned DATA_W = 32
) (
	// Clock
	input  wire logic              clk,
	// Write port
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [DATA_W-1:0] wdata,
	// Read port
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] rdata_d;

	// Read path is purely combinational before the output register
	always_comb begin
		rdata_d = mem[raddr];
	end

	// Storage has no reset, and neither has the output register
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= rdata_d;
	end
endmodule // bsl_frame_mem

/* File: testbench/bsl_src.sv */
`timescale 1ns/1ps
// Stand-in for the flash, host or probe feeding the loader
module bsl_src (
	// Link pins
	output logic        config_clock,
	output logic [31:0] cfg_data
);
	initial begin
		config_clock = 1'b0;
		cfg_data = 32'h00000000;
	end
	// One word as beats of the given width, MSB first; clock idles low
	task automatic send(input logic [31:0] w, input logic [1:0] wd);
		int n;
		logic [31:0] v;
		n = (wd == 2'h0) ? 32 : (wd == 2'h1) ? 4 : (wd == 2'h2) ? 2 : 1;
		for (int i = 0; i < n; i++) begin
			v = ~cfg_data; // Unused lines toggle, no stale bits
			case (wd)
				2'h0: v[0] = w[31-i];
				2'h1: v[7:0] = w[31-8*i -: 8];
				2'h2: v[15:0] = w[31-16*i -: 16];
				default: v = w;
			endcase
			cfg_data = v;
			#32 config_clock = 1'b1;
			#32 config_clock = 1'b0;
		end
		#16 cfg_data = ~cfg_data; // Released lines do not hold the last word
		#16; // Gap keeps one data change per time step between words
	endtask
endmodule // bsl_src

/* File: testbench/bsl_loader_monitor.sv */
`timescale 1ns/1ps
// Watches the loader's pin enables and status at its ports
module bsl_loader_monitor (
	// Clock and reset
	input wire logic                     clk,
	input wire logic                     rst_n,
	// Pins and controls
	input wire logic                     prog_n,
	input wire logic                     abort_req,
	input wire logic [2:0]               mode_pins,
	input wire logic                     init_oe_n,
	input wire logic                     done_oe_n,
	input wire logic                     done_i,
	input wire logic                     icap_en,
	input wire logic [1:0]               icap_width,
	// Status
	input wire logic [1:0]               detected_width,
	input wire logic                     sync_aligned_flag,
	input wire logic [bsl_pkg::BS_W-1:0] boot_status_reg,
	input wire logic                     fallback_req,
	input wire logic                     port_dead
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Failure states other than desync keep the init pin pulled low
	sequence s_init_low;
		(!init_oe_n) [*4];
	endsequence
	sequence s_done_seen;
		(icap_en && done_oe_n && done_i) [*4];
	endsequence
	// Abort pin reaches the flag through two flip-flops
	property p_flag;
		sync_aligned_flag |-> $past(abort_req, 2) && (mode_pins == 3'h4 || mode_pins == 3'h6);
	endproperty
	a_flag: assert property (p_flag) else $error("aligned flag shown");
	// Serial modes never pick up a parallel width
	property p_x1;
		init_oe_n && !icap_en && (mode_pins inside {3'h0, 3'h1, 3'h5, 3'h7})
			|-> detected_width == bsl_pkg::W_X1;
	endproperty
	a_x1: assert property (p_x1) else $error("width in serial mode");
	property p_icap;
		s_done_seen |-> detected_width == icap_width;
	endproperty
	a_icap: assert property (p_icap) else $error("internal width not shown");
	property p_fb;
		fallback_req |=> !fallback_req && boot_status_reg[bsl_pkg::BS_FALLBACK] ##[0:2] !init_oe_n;
	endproperty
	a_fb: assert property (p_fb) else $error("fallback pulse");
	property p_crc;
		$rose(boot_status_reg[bsl_pkg::BS_CRC_ERR]) |-> ##[0:2] s_init_low;
	endproperty
	a_crc: assert property (p_crc) else $error("crc error init");
	property p_hmac;
		$rose(boot_status_reg[bsl_pkg::BS_HMAC_ERR])
			|-> !boot_status_reg[bsl_pkg::BS_CRC_ERR] ##[0:2] s_init_low;
	endproperty
	a_hmac: assert property (p_hmac) else $error("hmac error");
	// Only the reprogram pin lifts a dead interface
	property p_dead;
		port_dead && prog_n |=> port_dead && !init_oe_n;
	endproperty
	a_dead: assert property (p_dead) else $error("dead port revived");
	property p_desync;
		(prog_n && boot_status_reg[bsl_pkg::BS_DESYNC]) [*3] |-> init_oe_n && !done_oe_n;
	endproperty
	a_desync: assert property (p_desync) else $error("desync pins");
endmodule // bsl_loader_monitor

bind bsl_loader bsl_loader_monitor mon (.clk(clk), .rst_n(rst_n), .prog_n(prog_n),
	.abort_req(abort_req), .mode_pins(mode_pins), .init_oe_n(init_oe_n),
	.done_oe_n(done_oe_n), .done_i(done_i), .icap_en(icap_en), .icap_width(icap_width),
	.detected_width(detected_width), .sync_aligned_flag(sync_aligned_flag),
	.boot_status_reg(boot_status_reg), .fallback_req(fallback_req), .port_dead(port_dead));

/* File: testbench/bsl_loader_test.sv */
`timescale 1ns/1ps
module bsl_loader_test;
	// Arbitrary identity fields, equal to the loader defaults
	localparam logic [31:0] IDW = {4'h0, 7'h01, 4'h1, 5'h01, 11'h001, 1'b1};
	typedef struct {logic [2:0] m; logic [31:0] p; logic [1:0] w;} bsl_row_t;
	// Mode, raw width pattern, width to report
	bsl_row_t rows [8] = '{'{3'h0, 32'hA1A2A3A4, 2'h0}, '{3'h1, 32'h000000A1, 2'h0},
		'{3'h5, 32'h0000A1A2, 2'h0}, '{3'h3, 32'h0000A1A2, 2'h2},
		'{3'h6, 32'hA1A2A3A4, 2'h3}, '{3'h4, 32'h000000A1, 2'h1},
		'{3'h2, 32'h12345678, 2'h1}, '{3'h7, 32'h000000A1, 2'h0}};
	logic        clk = 1'b0, rst_n = 1'b0, prog_n = 1'b1, abort_req = 1'b0;
	logic        icap_en = 1'b0, hmac_fail = 1'b0;
	logic [1:0]  icap_width = 2'h0, bw, detected_width;
	logic [2:0]  mode_pins = 3'h0;
	logic [9:0]  rd_addr = 10'h001;
	logic        config_clock, init_o, init_oe_n, done_o, done_oe_n, flag, fb, dead;
	logic [31:0] cfg_data, identity_word, rd_data, crc;
	logic [5:0]  bs, flash_addr;
	int          n_mismatch = 0, cmp_count = 0, cyc = 0;
	// Open-drain pins with pull-ups
	wire init_i = init_oe_n ? 1'b1 : init_o;
	wire done_i = done_oe_n ? 1'b1 : done_o;
	always #2 clk = ~clk;
	// Hang guard, well above the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			test_done();
		end
	end
	bsl_src src (.config_clock(config_clock), .cfg_data(cfg_data));
	// Small address width so a wrap is reachable
	bsl_loader #(.FLASH_AW(6)) uut (.clk(clk), .rst_n(rst_n), .config_clock(config_clock),
		.cfg_data(cfg_data), .mode_pins(mode_pins), .prog_n(prog_n), .abort_req(abort_req),
		.init_i(init_i), .init_o(init_o), .init_oe_n(init_oe_n), .done_i(done_i),
		.done_o(done_o), .done_oe_n(done_oe_n), .icap_en(icap_en), .icap_width(icap_width),
		.hmac_fail(hmac_fail), .identity_word(identity_word),
		.detected_width(detected_width), .sync_aligned_flag(flag), .boot_status_reg(bs),
		.fallback_req(fb), .port_dead(dead), .flash_addr(flash_addr), .rd_addr(rd_addr),
		.rd_data(rd_data));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] crc_w(input logic [31:0] c, input logic [31:0] d);
		for (int i = 31; i >= 0; i--)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? bsl_pkg::CRC_POLY : 32'h00000000);
		return c;
	endfunction
	task automatic tx(input logic [31:0] w);
		crc = crc_w(crc, w);
		src.send(w, bw);
	endtask
	// Waits for the init pin release, then leaves setup margin
	task automatic wait_init();
		int k;
		k = 0;
		repeat (4) @(negedge clk);
		while (init_oe_n !== 1'b1 && k < 600) begin
			@(negedge clk);
			k++;
		end
		repeat (10) @(negedge clk);
		bw = 2'h1;
	endtask
	// Mode changes only while the reprogram pin is low
	task automatic restart(input logic [2:0] m);
		@(negedge clk);
		prog_n = 1'b0;
		repeat (4) @(negedge clk);
		mode_pins = m;
		repeat (4) @(negedge clk);
		prog_n = 1'b1;
		wait_init();
	endtask
	// Full image: width pattern, sync, identity, two frames, CRC check, end
	task automatic stream(input logic [31:0] idw, input logic enc, input logic [31:0] bad);
		src.send(bsl_pkg::DET_X8, 2'h3);
		src.send(bsl_pkg::SYNC_WORD, bw);
		crc = bsl_pkg::CRC_INIT;
		tx(32'h00000000);
		tx(32'h10000000);
		tx(idw);
		if (enc)
			tx(32'h40000000);
		tx(32'h20000002);
		tx(32'hC0DE0001);
		tx(32'h5A5AA5A5);
		tx(32'h30000000);
		src.send(crc ^ bad, bw);
		tx(32'h50000000);
		repeat (16) @(negedge clk);
	endtask
	task automatic test_done();
		$display("TB: %0d compares, %0d mismatches", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk(bs, 6'h00);
		chk(init_oe_n, 1'b0);
		chk(flag, 1'b0);
		chk(identity_word, IDW);
		$display("TB: reset done");
		foreach (rows[i]) begin
			restart(rows[i].m);
			src.send(rows[i].p, 2'h3);
			bw = rows[i].w;
			stream(IDW, 1'b0, 32'h00000000);
			chk(detected_width, rows[i].w);
			chk(done_oe_n, 1'b1);
			chk(rd_data, 32'h5A5AA5A5);
			$display("TB: row %0d done", i);
		end
		icap_en = 1'b1;
		icap_width = 2'h2;
		repeat (8) @(negedge clk);
		chk(detected_width, 2'h2);
		icap_en = 1'b0;
		restart(3'h6);
		stream(IDW, 1'b0, 32'h00000001);
		chk(bs, 6'h02);
		restart(3'h4);
		stream(IDW, 1'b0, 32'h00000001);
		chk(bs, 6'h22);
		$display("TB: crc done");
		restart(3'h4);
		src.send(bsl_pkg::DET_X8, 2'h3);
		src.send(bsl_pkg::SYNC_WORD, bw);
		abort_req = 1'b1;
		repeat (8) @(negedge clk);
		chk(flag, 1'b1);
		abort_req = 1'b0;
		repeat (8) @(negedge clk);
		chk(flag, 1'b0);
		stream(IDW, 1'b0, 32'h00000000);
		chk(done_oe_n, 1'b1);
		restart(3'h6);
		src.send(bsl_pkg::DET_X8, 2'h3);
		src.send(bsl_pkg::SYNC_WORD, bw);
		src.send(32'hF0000000, bw);
		stream(IDW, 1'b0, 32'h00000000);
		chk(bs, 6'h10);
		chk(done_oe_n, 1'b0);
		restart(3'h6);
		hmac_fail = 1'b1;
		stream(IDW, 1'b1, 32'h00000001);
		chk(bs, 6'h04);
		hmac_fail = 1'b0;
		$display("TB: abort, desync, hmac done");
		restart(3'h3);
		stream(~IDW, 1'b0, 32'h00000000);
		chk(bs, 6'h21);
		wait_init();
		stream(~IDW, 1'b0, 32'h00000000);
		chk(dead, 1'b1);
		restart(3'h2);
		chk(dead, 1'b0);
		repeat (60) src.send(32'h00000000, 2'h3);
		chk(flash_addr, 6'h3C);
		repeat (10) src.send(32'h00000000, 2'h3);
		chk(bs, 6'h28);
		$display("TB: fallback done");
		test_done();
	end
endmodule // bsl_loader_test
